// >>> dv/core_model.sv
// core side model that services the done interrupt
`timescale 1ns/10ps
`default_nettype none
module core_model (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic nv_irq_request,
  output logic irq_service
);
  logic [1:0] wait_q;
  // services a taken request a few cycles late
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_q <= 2'h0;
      irq_service <= 1'b0;
    end else begin
      irq_service <= nv_irq_request && wait_q == 2'h3;
      wait_q <= (nv_irq_request && !irq_service) ? wait_q + 2'h1 : 2'h0;
    end
  end
endmodule : core_model
`default_nettype wire

// >>> dv/nv_asserts.sv
// port checker for the nonvolatile access controller
`timescale 1ns/10ps
`default_nettype none
module nv_asserts #(parameter bit LARGE_VARIANT = 1'b1) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr_en,
  input wire logic sfr_rd_en,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic nv_done_irq_enable,
  input wire logic global_irq_enable,
  input wire logic stack_full,
  input wire logic irq_service,
  input wire logic nv_done_irq_flag,
  input wire logic nv_irq_request,
  input wire logic busy
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  localparam logic [7:0] W_LEN = 8'(nv_pkg::WRITE_CYCLES_INT);
  localparam logic [7:0] R_LEN = 8'(nv_pkg::READ_CYCLES_INT);
  logic [7:0] cnt_q;
  logic wr_q;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 8'h00;
      wr_q <= 1'b0;
    end else begin
      cnt_q <= busy ? cnt_q + 8'h01 : 8'h00;
      if (sfr_wr_en && !busy) wr_q <= sfr_wdata[2];
    end
  end
  sequence s_end;
    $fell(busy);
  endsequence
  a_cycle_len: assert property (s_end |->
    cnt_q == (wr_q ? W_LEN : R_LEN)) else $error("cycle length wrong");
  a_busy_cause: assert property ($rose(busy) |->
    $past(sfr_wr_en)) else $error("cycle without write");
  a_flag_cause: assert property ($rose(nv_done_irq_flag) |->
    s_end) else $error("flag set outside cycle end");
  a_flag_sticky: assert property (nv_done_irq_flag && !irq_service
    |=> nv_done_irq_flag) else $error("flag dropped");
  a_service_clr: assert property (irq_service && !busy
    |=> !nv_done_irq_flag) else $error("flag not cleared");
  a_req_gate: assert property (nv_irq_request ==
    (nv_done_irq_flag && nv_done_irq_enable && global_irq_enable &&
    !stack_full)) else $error("request gating wrong");
  a_rdata_hold: assert property (!sfr_rd_en |=>
    $stable(sfr_rdata)) else $error("read data moved");
  a_ctrl_hidden: assert property (sfr_rd_en && sfr_addr == 8'h40
    |=> sfr_rdata == 8'h00) else $error("control seen directly");
  a_high_zero: assert property (sfr_rd_en && sfr_addr == 8'h21
    |=> sfr_rdata[7:2] == 6'h00 && (LARGE_VARIANT || !sfr_rdata[1]))
    else $error("high bits not zero");
endmodule : nv_asserts
bind eeprom_byte_access_controller nv_asserts #(
  .LARGE_VARIANT(LARGE_VARIANT)) i_chk (
  .core_clk(core_clk),
  .reset_n(reset_n),
  .sfr_addr(sfr_addr),
  .sfr_wr_en(sfr_wr_en),
  .sfr_rd_en(sfr_rd_en),
  .sfr_wdata(sfr_wdata),
  .sfr_rdata(sfr_rdata),
  .nv_done_irq_enable(nv_done_irq_enable),
  .global_irq_enable(global_irq_enable),
  .stack_full(stack_full),
  .irq_service(irq_service),
  .nv_done_irq_flag(nv_done_irq_flag),
  .nv_irq_request(nv_irq_request),
  .busy(busy));
`default_nettype wire

// >>> dv/testbench.sv
// self-checking bench for the nonvolatile access controller
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic core_clk = 1'b0, reset_n = 1'b0, sfr_wr_en = 1'b0, sfr_rd_en = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, rv;
  logic en = 1'b0, glob = 1'b0, stk = 1'b0, srv, flag, req, busy;
  int fails = 0, tests_run = 0;
  eeprom_byte_access_controller i_dut (.core_clk(core_clk),
    .reset_n(reset_n), .sfr_addr(sfr_addr), .sfr_wr_en(sfr_wr_en),
    .sfr_rd_en(sfr_rd_en), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .nv_done_irq_enable(en), .global_irq_enable(glob), .stack_full(stk),
    .irq_service(srv), .nv_done_irq_flag(flag), .nv_irq_request(req),
    .busy(busy));
  core_model i_core (.core_clk(core_clk), .reset_n(reset_n),
    .nv_irq_request(req), .irq_service(srv));
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      fails++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic end_of_test();
    if (fails == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge core_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr_en <= 1'b1;
    @(posedge core_clk);
    sfr_wr_en <= 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] a);
    @(posedge core_clk);
    sfr_addr <= a;
    sfr_rd_en <= 1'b1;
    @(posedge core_clk);
    sfr_rd_en <= 1'b0;
    @(negedge core_clk);
    rv = sfr_rdata;
  endtask : rd
  task automatic idle();
    @(negedge core_clk);
    for (int i = 0; i < 200 && busy !== 1'b0; i++) @(negedge core_clk);
    chk("busy_end", {7'h0, busy}, 8'h00);
  endtask : idle
  task automatic t_reset();
    for (int a = 8'h20; a < 8'h23; a++) begin
      rd(8'(a));
      chk("reg_reset", rv, 8'h00);
    end
    rd(8'h04);
    chk("bank_reset", rv, 8'h00);
    wr(8'h03, 8'h40);
    rd(8'h02);
    chk("ctrl_bank0", rv, 8'h00);
    wr(8'h04, 8'h01);
    rd(8'h02);
    chk("ctrl_reset", rv, 8'h00);
  endtask : t_reset
  task automatic t_write(logic [9:0] a, logic [7:0] d);
    wr(8'h20, a[7:0]);
    wr(8'h21, {6'h3f, a[9:8]});
    wr(8'h22, d);
    wr(8'h02, 8'h0a);
    wr(8'h02, 8'h0e);
    @(negedge core_clk);
    chk("wr_busy", {7'h0, busy}, 8'h01);
    wr(8'h02, 8'h0b);
    rd(8'h02);
    chk("ctrl_run", rv, 8'h0e);
    idle();
    rd(8'h02);
    chk("ctrl_done", rv, 8'h0a);
    chk("flag_set", {7'h0, flag}, 8'h01);
    rd(8'h40);
    chk("ctrl_direct", rv, 8'h00);
  endtask : t_write
  task automatic t_read(logic [9:0] a, logic [7:0] d);
    wr(8'h21, {6'h3f, a[9:8]});
    rd(8'h21);
    chk("high_mask", rv, {6'h00, a[9:8]});
    wr(8'h20, a[7:0]);
    wr(8'h22, 8'h00);
    wr(8'h02, 8'h02);
    wr(8'h02, 8'h03);
    idle();
    rd(8'h02);
    chk("ctrl_rd", rv, 8'h02);
    rd(8'h22);
    chk("rd_data", rv, d);
  endtask : t_read
  task automatic t_refuse();
    logic [7:0] v[3] = '{8'h04, 8'h01, 8'h0f};
    logic [7:0] p[3] = '{8'h00, 8'h00, 8'h0a};
    for (int i = 0; i < 3; i++) begin
      wr(8'h02, p[i]);
      wr(8'h02, v[i]);
      @(negedge core_clk);
      chk("no_start", {7'h0, busy}, 8'h00);
    end
  endtask : t_refuse
  task automatic t_irq();
    @(posedge core_clk);
    en <= 1'b1;
    glob <= 1'b1;
    stk <= 1'b1;
    @(negedge core_clk);
    chk("req_stack", {7'h0, req}, 8'h00);
    @(posedge core_clk);
    stk <= 1'b0;
    @(negedge core_clk);
    chk("req_on", {7'h0, req}, 8'h01);
    repeat (8) @(negedge core_clk);
    chk("flag_srv", {7'h0, flag}, 8'h00);
  endtask : t_irq
  initial begin
    #100000;
    fails++;
    end_of_test();
  end
  initial begin
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    t_reset();
    t_write(10'h2a5, 8'h5a);
    t_write(10'h0a5, 8'ha5);
    t_irq();
    t_read(10'h2a5, 8'h5a);
    t_read(10'h0a5, 8'ha5);
    t_refuse();
    end_of_test();
  end
endmodule : testbench
`default_nettype wire

// >>> pkg/nv_pkg.sv
// constants and types for the nonvolatile byte access controller
package nv_pkg;

  // ----------------------------------------------------------------
  // clock and cycle timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int WRITE_TIME_NS = 4000;
  localparam int READ_TIME_NS = 80;
  localparam int WRITE_CYCLES_INT =
    (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_CYCLES_INT =
    (READ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] WRITE_CYCLES = CNT_W'(WRITE_CYCLES_INT);
  localparam logic [CNT_W-1:0] READ_CYCLES = CNT_W'(READ_CYCLES_INT);
  localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;

  // ----------------------------------------------------------------
  // register offsets in the special function area
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_IND_PORT_ONE = 8'h02;
  localparam logic [7:0] OFF_IND_PTR_ONE = 8'h03;
  localparam logic [7:0] OFF_BANK_SEL = 8'h04;
  localparam logic [7:0] OFF_ADDR_LOW = 8'h20;
  localparam logic [7:0] OFF_ADDR_HIGH = 8'h21;
  localparam logic [7:0] OFF_DATA = 8'h22;
  localparam logic [7:0] OFF_CONTROL = 8'h40;
  localparam logic BANK_CONTROL = 1'b1;

  // ----------------------------------------------------------------
  // control field positions
  // ----------------------------------------------------------------
  localparam int BIT_FETCH_GO = 0;
  localparam int BIT_FETCH_PERMIT = 1;
  localparam int BIT_PROG_GO = 2;
  localparam int BIT_PROG_PERMIT = 3;

  // ----------------------------------------------------------------
  // reset values and array geometry
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic RST_BIT = 1'b0;
  localparam logic [7:0] HIGH_MASK_SMALL = 8'h01;
  localparam logic [7:0] HIGH_MASK_LARGE = 8'h03;
  localparam int ARRAY_BYTES_LARGE = 1024;
  localparam int ARRAY_ADDR_W = 10;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01,
    ST_PROGRAM = 2'b10
  } cycle_state_type;

endpackage : nv_pkg

// >>> src/eeprom_byte_access_controller.sv
// nonvolatile byte array with its core-side access registers
`timescale 1ns/10ps
`default_nettype none

// How it works
// [RULE_01] array of 512 or 1024 bytes
// [RULE_02] single byte moves; address/data direct, control indirect
// [RULE_03] software points indirectly at 0x40 in bank 1
// [RULE_04] low register bits 7-0, high gives 8/9
// [RULE_05] unused high and control bits read zero
// [RULE_06] program permit gates every write cycle
// [RULE_07] program go starts write, self-clears at end
// [RULE_08] program go ignored without prior permit
// [RULE_09] fetch permit gates every read cycle
// [RULE_10] fetch go starts read, self-clears at end
// [RULE_11] fetch go ignored without prior permit
// [RULE_12] software never sets both go bits together
// [RULE_13] data register keeps fetched byte until next cycle
// [RULE_14] software sets permit then go next instruction
// [RULE_15] software masks interrupts around write start
// [RULE_16] write timed internally, end clears program go
// [RULE_17] reset clears program permit and bank select
// [RULE_18] bank select zero hides control after reset
// [RULE_19] write end sets the done flag
// [RULE_20] done request gated by enables, stack; service clears
// [RULE_21] software sets done enable for notification
// [RULE_22] software waits for cycle end before sleep
// [RULE_23] new go ignored while a cycle runs
module eeprom_byte_access_controller #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr_en,
  input wire logic sfr_rd_en,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic nv_done_irq_enable,
  input wire logic global_irq_enable,
  input wire logic stack_full,
  input wire logic irq_service,
  output logic nv_done_irq_flag,
  output logic nv_irq_request,
  output logic busy
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  nv_pkg::cycle_state_type state_q;
  nv_pkg::cycle_state_type state_d;
  logic [nv_pkg::CNT_W-1:0] cnt_q;
  logic [nv_pkg::CNT_W-1:0] cnt_d;
  logic [7:0] addr_low_q;
  logic [7:0] addr_high_q;
  logic [7:0] data_q;
  logic [7:0] ptr_q;
  logic bank_q;
  logic prog_permit_q;
  logic prog_go_q;
  logic fetch_permit_q;
  logic fetch_go_q;
  logic done_flag_q;
  logic [7:0] rdata_q;
  logic [nv_pkg::ARRAY_ADDR_W-1:0] cyc_addr_q;
  logic [7:0] mem [0:nv_pkg::ARRAY_BYTES_LARGE-1];

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire is_ind = sfr_addr == nv_pkg::OFF_IND_PORT_ONE;
  wire eff_bank = is_ind ? bank_q : 1'b0;
  wire [7:0] eff_off = is_ind ? ptr_q : sfr_addr;
  wire sel_ptr = eff_off == nv_pkg::OFF_IND_PTR_ONE;
  wire sel_bank = eff_off == nv_pkg::OFF_BANK_SEL;
  wire sel_low = eff_off == nv_pkg::OFF_ADDR_LOW;
  wire sel_high = eff_off == nv_pkg::OFF_ADDR_HIGH;
  wire sel_data = eff_off == nv_pkg::OFF_DATA;
  wire sel_ctrl = (eff_off == nv_pkg::OFF_CONTROL) &&
    (eff_bank == nv_pkg::BANK_CONTROL); // [RULE_02] [RULE_18]
  wire wr_ptr = sfr_wr_en & sel_ptr;
  wire wr_bank = sfr_wr_en & sel_bank;
  wire wr_low = sfr_wr_en & sel_low;
  wire wr_high = sfr_wr_en & sel_high;
  wire wr_data = sfr_wr_en & sel_data;
  wire wr_ctrl = sfr_wr_en & sel_ctrl;

  // ----------------------------------------------------------------
  // cycle launch and completion
  // ----------------------------------------------------------------
  wire idle = state_q == nv_pkg::ST_IDLE;
  wire w_pg = sfr_wdata[nv_pkg::BIT_PROG_GO];
  wire w_fg = sfr_wdata[nv_pkg::BIT_FETCH_GO];
  wire start_prog = wr_ctrl & w_pg & ~w_fg & prog_permit_q &
    idle; // [RULE_06] [RULE_08] [RULE_23]
  wire start_fetch = wr_ctrl & w_fg & ~w_pg & fetch_permit_q &
    idle; // [RULE_09] [RULE_11] [RULE_23]
  wire cnt_last = cnt_q == nv_pkg::CNT_ONE;
  wire end_prog = (state_q == nv_pkg::ST_PROGRAM) & cnt_last;
  wire end_fetch = (state_q == nv_pkg::ST_FETCH) & cnt_last;
  wire [7:0] high_mask = LARGE_VARIANT ? nv_pkg::HIGH_MASK_LARGE :
    nv_pkg::HIGH_MASK_SMALL;
  wire [nv_pkg::ARRAY_ADDR_W-1:0] held_addr =
    {addr_high_q[1:0], addr_low_q}; // [RULE_04] [RULE_01]
  wire [7:0] fetched_byte = mem[cyc_addr_q];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      nv_pkg::ST_IDLE: begin
        if (start_prog) begin
          state_d = nv_pkg::ST_PROGRAM;
          cnt_d = nv_pkg::WRITE_CYCLES; // [RULE_16]
        end else if (start_fetch) begin
          state_d = nv_pkg::ST_FETCH;
          cnt_d = nv_pkg::READ_CYCLES;
        end
      end
      nv_pkg::ST_FETCH,
      nv_pkg::ST_PROGRAM: begin
        if (cnt_last) begin
          state_d = nv_pkg::ST_IDLE;
        end else begin
          cnt_d = cnt_q - nv_pkg::CNT_ONE;
        end
      end
      default: begin
        state_d = nv_pkg::ST_IDLE;
        cnt_d = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= nv_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // cycle timer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d; // [RULE_16]
    end
  end

  // ----------------------------------------------------------------
  // pointer, bank select and address registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ptr_q <= nv_pkg::RST_BYTE;
    end else if (wr_ptr) begin
      ptr_q <= sfr_wdata;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      bank_q <= nv_pkg::RST_BIT; // [RULE_17] [RULE_18]
    end else if (wr_bank) begin
      bank_q <= sfr_wdata[0];
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_low_q <= nv_pkg::RST_BYTE;
    end else if (wr_low) begin
      addr_low_q <= sfr_wdata;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_high_q <= nv_pkg::RST_BYTE;
    end else if (wr_high) begin
      addr_high_q <= sfr_wdata & high_mask; // [RULE_04] [RULE_05]
    end
  end

  // ----------------------------------------------------------------
  // data register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      data_q <= nv_pkg::RST_BYTE;
    end else if (end_fetch) begin
      data_q <= fetched_byte; // [RULE_13] [RULE_02]
    end else if (wr_data) begin
      data_q <= sfr_wdata;
    end
  end

  // ----------------------------------------------------------------
  // control bits
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prog_permit_q <= nv_pkg::RST_BIT; // [RULE_17]
      fetch_permit_q <= nv_pkg::RST_BIT;
    end else if (wr_ctrl) begin
      prog_permit_q <= sfr_wdata[nv_pkg::BIT_PROG_PERMIT]; // [RULE_06]
      fetch_permit_q <= sfr_wdata[nv_pkg::BIT_FETCH_PERMIT]; // [RULE_09]
    end
  end

  // ----------------------------------------------------------------
  // program go
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prog_go_q <= nv_pkg::RST_BIT;
    end else if (start_prog) begin
      prog_go_q <= 1'b1; // [RULE_07]
    end else if (end_prog) begin
      prog_go_q <= 1'b0; // [RULE_07] [RULE_16]
    end
  end

  // ----------------------------------------------------------------
  // fetch go
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      fetch_go_q <= nv_pkg::RST_BIT;
    end else if (start_fetch) begin
      fetch_go_q <= 1'b1; // [RULE_10]
    end else if (end_fetch) begin
      fetch_go_q <= 1'b0; // [RULE_10]
    end
  end

  // ----------------------------------------------------------------
  // array access
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cyc_addr_q <= '0;
    end else if (start_prog | start_fetch) begin
      cyc_addr_q <= held_addr; // [RULE_04]
    end
  end

  always_ff @(posedge core_clk) begin
    if (end_prog) begin
      mem[cyc_addr_q] <= data_q; // [RULE_07] [RULE_01]
    end
  end

  // ----------------------------------------------------------------
  // done flag and request
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      done_flag_q <= nv_pkg::RST_BIT;
    end else if (end_prog) begin
      done_flag_q <= 1'b1; // [RULE_19]
    end else if (irq_service) begin
      done_flag_q <= 1'b0; // [RULE_20]
    end
  end

  assign nv_done_irq_flag = done_flag_q;
  assign nv_irq_request = done_flag_q & nv_done_irq_enable &
    global_irq_enable & ~stack_full; // [RULE_20]
  assign busy = ~idle;

  // ----------------------------------------------------------------
  // read back
  // ----------------------------------------------------------------
  wire [7:0] ctrl_view = {4'h0, prog_permit_q, prog_go_q,
    fetch_permit_q, fetch_go_q}; // [RULE_05]
  wire [7:0] bank_view = {7'h00, bank_q};
  wire [7:0] high_view = addr_high_q & high_mask; // [RULE_05]
  wire [7:0] rd_mux =
    sel_ctrl ? ctrl_view :
    sel_ptr ? ptr_q :
    sel_bank ? bank_view :
    sel_low ? addr_low_q :
    sel_high ? high_view :
    sel_data ? data_q :
    nv_pkg::RST_BYTE;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= nv_pkg::RST_BYTE;
    end else if (sfr_rd_en) begin
      rdata_q <= rd_mux;
    end
  end

  assign sfr_rdata = rdata_q;

endmodule : eeprom_byte_access_controller
`default_nettype wire
